// [verilog/converter_power_sync_config_regs.sv]
// Power-down mask, sync and reference/clock/input configuration bank.
// Assumes SPI and shared pins are asynchronous to clk_sys_i; the global
// power-down bit comes from logic on the same clock.
`timescale 1ns/1ps
module converter_power_sync_config_regs
#(
   parameter int WAKE_SHORT = converter_cfg_pkg::WAKE_SHORT_CYC,
   parameter int WAKE_LONG  = converter_cfg_pkg::WAKE_LONG_CYC
)
(
   // Clock and reset
   input  wire logic       clk_sys_i,
   input  wire logic       reset_i,
   // Global power-down request from the power register
   input  wire logic       global_powerdown_bit_i,
   // Serial configuration port
   input  wire logic       spi_sen_n_i,
   input  wire logic       spi_sclk_i,
   input  wire logic       spi_sdi_i,
   output logic            spi_sdo_o,
   output logic            spi_sdo_oe_o,
   // Device pins
   input  wire logic       sync_powerdown_shared_pin_i,
   input  wire logic [1:0] reference_buffer_pin_i,
   // Power controls
   output logic            global_powerdown_active_o,
   output logic            converter_core_on_o,
   output logic            clock_buffer_on_o,
   output logic            reference_amp_on_o,
   output logic            bandgap_on_o,
   output logic            wake_done_o,
   // Synchronisation
   output logic            sync_pulse_o,
   // Reference and clock input
   output logic [1:0]      reference_source_o,
   output logic            single_ended_clock_select_o,
   // Analog input and sampling
   output logic            chan_a_single_ended_o,
   output logic            chan_b_single_ended_o,
   output logic            delay_loop_powerdown_o,
   output logic            autozero_enable_o
);

   import converter_cfg_pkg::*;

   // Synchronised pins
   logic       sen_n_s;
   logic       sclk_s;
   logic       sdi_s;
   logic       shared_pin_s;
   logic [1:0] ref_pin_s;
   logic       sclk_q;
   logic       shared_pin_q;
   logic       sclk_rise;
   logic       sclk_fall;
   logic       shared_pin_rise;

   // Register side of the serial port
   logic [6:0] reg_addr;
   logic [7:0] reg_wdata;
   logic       reg_write;
   logic [7:0] reg_rdata;

   // Register contents
   logic [7:0] powerdown_keep_mask;
   logic [7:0] sync_reference_clock_control;
   logic [7:0] input_sampling_control;

   // Field views
   logic       clock_buffer_keep_mask;
   logic       reference_amp_keep_mask;
   logic       bandgap_off_mask;
   logic       sync_pin_role;
   logic       sync_trigger;
   logic       sync_by_register;
   logic       reference_source_authority;
   logic [1:0] reference_field;
   logic       single_ended_clock_select;

   // Derived controls
   logic       trigger_q;
   logic       next_gpd;
   logic [1:0] next_reference;
   logic       next_se_clock;

   // Wake-up sequencing
   pwr_state_t            pwr_state;
   logic [WAKE_CNT_W-1:0] wake_cnt;
   logic                  bandgap_was_off;

   pin_sync
   #(
      .W    (6),
      .INIT (6'h01)
   )
   u_pin_sync
   (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .async_i   ({reference_buffer_pin_i,
                   sync_powerdown_shared_pin_i,
                   spi_sdi_i,
                   spi_sclk_i,
                   spi_sen_n_i}),
      .sync_o    ({ref_pin_s,
                   shared_pin_s,
                   sdi_s,
                   sclk_s,
                   sen_n_s})
   );

   // Edge detection on synchronised levels
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         sclk_q       <= 1'b0;
         shared_pin_q <= 1'b0;
      end
      else
      begin
         sclk_q       <= sclk_s;
         shared_pin_q <= shared_pin_s;
      end
   end

   assign sclk_rise       = sclk_s & ~sclk_q;
   assign sclk_fall       = ~sclk_s & sclk_q;
   assign shared_pin_rise = shared_pin_s & ~shared_pin_q;

   spi_frame u_spi_frame
   (
      .clk_sys_i   (clk_sys_i),
      .reset_i     (reset_i),
      .sen_n_i     (sen_n_s),
      .sclk_rise_i (sclk_rise),
      .sclk_fall_i (sclk_fall),
      .sdi_i       (sdi_s),
      .rd_data_i   (reg_rdata),
      .addr_o      (reg_addr),
      .wr_data_o   (reg_wdata),
      .wr_strobe_o (reg_write),
      .sdo_o       (spi_sdo_o),
      .sdo_oe_o    (spi_sdo_oe_o)
   );

   // Register writes keep only defined bits; all reset to zero
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         powerdown_keep_mask          <= KEEP_MASK_RST;
         sync_reference_clock_control <= SYNC_REF_RST;
         input_sampling_control       <= INPUT_RST;
      end
      else if (reg_write)
      begin
         case (reg_addr)
            OFS_KEEP_MASK:
               powerdown_keep_mask <= reg_wdata & KEEP_MASK_WMASK;
            OFS_SYNC_REF:
               // Trigger bit is only ever changed by a host write
               sync_reference_clock_control <=
                  reg_wdata & SYNC_REF_WMASK;
            OFS_INPUT:
               input_sampling_control <= reg_wdata & INPUT_WMASK;
            default:
               ;
         endcase
      end
   end

   // Readback; unmapped addresses read zero
   always_comb
   begin
      case (reg_addr)
         OFS_KEEP_MASK:
            reg_rdata = powerdown_keep_mask;
         OFS_SYNC_REF:
            reg_rdata = sync_reference_clock_control;
         OFS_INPUT:
            reg_rdata = input_sampling_control;
         default:
            reg_rdata = 8'h00;
      endcase
   end

   assign clock_buffer_keep_mask =
      powerdown_keep_mask[KEEP_CLKBUF_BIT];
   assign reference_amp_keep_mask =
      powerdown_keep_mask[KEEP_REFAMP_BIT];
   assign bandgap_off_mask =
      powerdown_keep_mask[BANDGAP_OFF_BIT];
   assign sync_pin_role =
      sync_reference_clock_control[SYNC_PIN_ROLE_BIT];
   assign sync_trigger =
      sync_reference_clock_control[REG_SYNC_TRIG_BIT];
   assign sync_by_register =
      sync_reference_clock_control[REG_SYNC_EN_BIT];
   assign reference_source_authority =
      sync_reference_clock_control[REF_AUTH_BIT];
   assign reference_field =
      sync_reference_clock_control[REF_SEL_MSB:REF_SEL_LSB];
   assign single_ended_clock_select =
      sync_reference_clock_control[SE_CLK_BIT];

   // Shared pin acts as power-down only in its power-down role
   assign next_gpd = global_powerdown_bit_i |
                     (~sync_pin_role & shared_pin_s);

   // Reference: pin or register field; the unused code falls back
   // to the internal reference
   always_comb
   begin
      next_reference = ref_pin_s;
      if (reference_source_authority)
      begin
         case (reference_field)
            REF_INTERNAL:
               next_reference = REF_INTERNAL;
            REF_EXT_BUF:
               next_reference = REF_EXT_BUF;
            REF_EXT_DIRECT:
               next_reference = REF_EXT_DIRECT;
            default:
               next_reference = REF_INTERNAL;
         endcase
      end
   end

   assign next_se_clock = reference_source_authority &
                          single_ended_clock_select;

   // Power outputs: core follows the global state; clock buffer and reference amp follow it unless kept; bandgap only when marked off
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         global_powerdown_active_o <= 1'b0;
         converter_core_on_o       <= 1'b1;
         clock_buffer_on_o         <= 1'b1;
         reference_amp_on_o        <= 1'b1;
         bandgap_on_o              <= 1'b1;
      end
      else
      begin
         global_powerdown_active_o <= next_gpd;
         converter_core_on_o       <= ~next_gpd;
         // Single-ended clock also turns the differential buffer off
         clock_buffer_on_o <=
            ~(next_gpd & ~clock_buffer_keep_mask) &
            ~next_se_clock;
         reference_amp_on_o <=
            ~(next_gpd & ~reference_amp_keep_mask);
         bandgap_on_o <=
            ~(next_gpd & bandgap_off_mask);
      end
   end

   // Wake-up wait, longer when the bandgap was taken down
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         pwr_state       <= PWR_ON;
         wake_cnt        <= '0;
         bandgap_was_off <= 1'b0;
         wake_done_o     <= 1'b1;
      end
      else
      begin
         case (pwr_state)
            PWR_ON:
               if (next_gpd)
               begin
                  pwr_state       <= PWR_DOWN;
                  bandgap_was_off <= bandgap_off_mask;
                  wake_done_o     <= 1'b0;
               end
            PWR_DOWN:
               if (!next_gpd)
               begin
                  pwr_state <= PWR_WAKE;
                  wake_cnt  <= bandgap_was_off ?
                     WAKE_CNT_W'(WAKE_LONG - 1) :
                     WAKE_CNT_W'(WAKE_SHORT - 1);
               end
               else if (bandgap_off_mask)
                  bandgap_was_off <= 1'b1;
            PWR_WAKE:
               if (next_gpd)
               begin
                  pwr_state       <= PWR_DOWN;
                  bandgap_was_off <= bandgap_was_off |
                                     bandgap_off_mask;
               end
               else if (wake_cnt == '0)
               begin
                  pwr_state   <= PWR_ON;
                  wake_done_o <= 1'b1;
               end
               else
                  wake_cnt <= wake_cnt - WAKE_CNT_W'(1);
            default:
               begin
                  pwr_state   <= PWR_ON;
                  wake_done_o <= 1'b1;
               end
         endcase
      end
   end

   // Synchronisation: register trigger edge or shared pin edge
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         trigger_q    <= 1'b0;
         sync_pulse_o <= 1'b0;
      end
      else
      begin
         trigger_q <= sync_trigger;
         if (sync_by_register)
            sync_pulse_o <= sync_trigger & ~trigger_q;
         else
            sync_pulse_o <= sync_pin_role & shared_pin_rise;
      end
   end

   // Reference, clock and input settings
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         reference_source_o          <= REF_INTERNAL;
         single_ended_clock_select_o <= 1'b0;
      end
      else
      begin
         reference_source_o          <= next_reference;
         single_ended_clock_select_o <= next_se_clock;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         chan_a_single_ended_o  <= 1'b0;
         chan_b_single_ended_o  <= 1'b0;
         delay_loop_powerdown_o <= 1'b0;
         autozero_enable_o      <= 1'b0;
      end
      else
      begin
         chan_a_single_ended_o <=
            input_sampling_control[CHAN_A_SE_BIT];
         chan_b_single_ended_o <=
            input_sampling_control[CHAN_B_SE_BIT];
         // Only meaningful below 40 MSPS; the host must see to that
         delay_loop_powerdown_o <=
            input_sampling_control[DELAY_PD_BIT];
         autozero_enable_o <=
            input_sampling_control[AUTOZERO_BIT];
      end
   end

endmodule

// [verilog/converter_cfg_pkg.sv]
// Constants and types shared by the converter configuration bank.
// Assumes one 200 MHz system clock; SPI pins arrive asynchronously.
package converter_cfg_pkg;

   // Serial frame: one read/write bit, seven address bits, eight data
   localparam int ADDR_W    = 7;
   localparam int DATA_W    = 8;
   localparam int CMD_BITS  = 8;
   localparam int DATA_BITS = 8;

   // Register offsets
   localparam logic [6:0] OFS_KEEP_MASK = 7'h0d;
   localparam logic [6:0] OFS_SYNC_REF  = 7'h0e;
   localparam logic [6:0] OFS_INPUT     = 7'h11;

   // Power-down keep mask fields
   localparam int KEEP_CLKBUF_BIT = 3;
   localparam int KEEP_REFAMP_BIT = 2;
   localparam int BANDGAP_OFF_BIT = 1;

   // Sync, reference and clock control fields
   localparam int SYNC_PIN_ROLE_BIT = 7;
   localparam int REG_SYNC_TRIG_BIT = 6;
   localparam int REG_SYNC_EN_BIT   = 5;
   localparam int REF_AUTH_BIT      = 3;
   localparam int REF_SEL_MSB       = 2;
   localparam int REF_SEL_LSB       = 1;
   localparam int SE_CLK_BIT        = 0;

   // Input and sampling control fields
   localparam int CHAN_A_SE_BIT = 5;
   localparam int CHAN_B_SE_BIT = 4;
   localparam int DELAY_PD_BIT  = 2;
   localparam int AUTOZERO_BIT  = 0;

   // Writable bits; reserved bits are not stored and read as zero
   localparam logic [7:0] KEEP_MASK_WMASK = 8'h0e;
   localparam logic [7:0] SYNC_REF_WMASK  = 8'hef;
   localparam logic [7:0] INPUT_WMASK     = 8'h35;

   // Reset values
   localparam logic [7:0] KEEP_MASK_RST = 8'h00;
   localparam logic [7:0] SYNC_REF_RST  = 8'h00;
   localparam logic [7:0] INPUT_RST     = 8'h00;

   // Reference source codes
   localparam logic [1:0] REF_INTERNAL   = 2'h0;
   localparam logic [1:0] REF_EXT_BUF    = 2'h1;
   localparam logic [1:0] REF_EXT_DIRECT = 2'h2;
   localparam logic [1:0] REF_UNUSED     = 2'h3;

   // Wake-up times after global power-down ends
   localparam int CLK_FREQ_MHZ  = 200;
   localparam int WAKE_SHORT_NS = 1000;
   localparam int WAKE_LONG_NS  = 10000;
   localparam int WAKE_SHORT_CYC =
      (WAKE_SHORT_NS * CLK_FREQ_MHZ + 999) / 1000;
   localparam int WAKE_LONG_CYC =
      (WAKE_LONG_NS * CLK_FREQ_MHZ + 999) / 1000;
   localparam int WAKE_CNT_W = 12;

   typedef enum logic [3:0] {
      SPI_IDLE = 4'b0001,
      SPI_CMD  = 4'b0010,
      SPI_DATA = 4'b0100,
      SPI_DONE = 4'b1000
   } spi_state_t;

   typedef enum logic [2:0] {
      PWR_ON   = 3'b001,
      PWR_DOWN = 3'b010,
      PWR_WAKE = 3'b100
   } pwr_state_t;

endpackage

// [verilog/pin_sync.sv]
// Two-stage synchroniser for a group of asynchronous pin levels.
// Assumes the pins change slowly next to the system clock.
`timescale 1ns/1ps
module pin_sync
#(
   parameter int         W    = 1,
   parameter logic [W-1:0] INIT = '0
)
(
   // Clock and reset
   input  wire logic         clk_sys_i,
   input  wire logic         reset_i,
   // Pins in, synchronised levels out
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);

   logic [W-1:0] stage1;

   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         stage1 <= INIT;
         sync_o <= INIT;
      end
      else
      begin
         stage1 <= async_i;
         sync_o <= stage1;
      end
   end

endmodule

// [verilog/spi_frame.sv]
// Serial frame engine: 8 command bits then 8 data bits, MSB first.
// Assumes synchronised pins and one-cycle SCLK edge strobes.
`timescale 1ns/1ps
module spi_frame
   import converter_cfg_pkg::*;
(
   // Clock and reset
   input  wire logic                                 clk_sys_i,
   input  wire logic                                 reset_i,
   // Synchronised serial pins
   input  wire logic                                 sen_n_i,
   input  wire logic                                 sclk_rise_i,
   input  wire logic                                 sclk_fall_i,
   input  wire logic                                 sdi_i,
   // Register side
   input  wire logic [converter_cfg_pkg::DATA_W-1:0] rd_data_i,
   output logic      [converter_cfg_pkg::ADDR_W-1:0] addr_o,
   output logic      [converter_cfg_pkg::DATA_W-1:0] wr_data_o,
   output logic                                      wr_strobe_o,
   // Serial data out
   output logic                                      sdo_o,
   output logic                                      sdo_oe_o
);

   spi_state_t state;
   logic [3:0] bit_cnt;
   logic       read_op;
   logic [7:0] rd_shift;

   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         state       <= SPI_IDLE;
         bit_cnt     <= 4'h0;
         read_op     <= 1'b0;
         addr_o      <= 7'h00;
         wr_data_o   <= 8'h00;
         wr_strobe_o <= 1'b0;
      end
      else
      begin
         wr_strobe_o <= 1'b0;
         if (sen_n_i)
         begin
            state   <= SPI_IDLE;
            bit_cnt <= 4'h0;
         end
         else
         begin
            case (state)
               SPI_IDLE:
                  state <= SPI_CMD;
               SPI_CMD:
                  if (sclk_rise_i)
                  begin
                     if (bit_cnt == 4'h0)
                        read_op <= sdi_i;
                     else
                        addr_o <= {addr_o[5:0], sdi_i};
                     if (bit_cnt == 4'(CMD_BITS - 1))
                     begin
                        bit_cnt <= 4'h0;
                        state   <= SPI_DATA;
                     end
                     else
                        bit_cnt <= bit_cnt + 4'h1;
                  end
               SPI_DATA:
                  if (sclk_rise_i)
                  begin
                     wr_data_o <= {wr_data_o[6:0], sdi_i};
                     if (bit_cnt == 4'(DATA_BITS - 1))
                     begin
                        wr_strobe_o <= ~read_op;
                        state       <= SPI_DONE;
                     end
                     else
                        bit_cnt <= bit_cnt + 4'h1;
                  end
               SPI_DONE:
                  state <= SPI_DONE;
               default:
                  state <= SPI_IDLE;
            endcase
         end
      end
   end

   // Read data leaves on falling SCLK so the host samples it on rising
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         sdo_o    <= 1'b0;
         sdo_oe_o <= 1'b0;
         rd_shift <= 8'h00;
      end
      else if (sen_n_i || !read_op || (state != SPI_DATA))
         sdo_oe_o <= 1'b0;
      else if (sclk_fall_i)
      begin
         sdo_oe_o <= 1'b1;
         if (bit_cnt == 4'h0 && !sdo_oe_o)
         begin
            sdo_o    <= rd_data_i[7];
            rd_shift <= {rd_data_i[6:0], 1'b0};
         end
         else
         begin
            sdo_o    <= rd_shift[7];
            rd_shift <= {rd_shift[6:0], 1'b0};
         end
      end
   end

endmodule

// [tb/cfg_bank_props.sv]
// Port checker for the converter configuration bank, bound to its top.
// Assumes one clock domain and the bank's synchronous reset.
`timescale 1ns/1ps
module cfg_bank_props
#(
   parameter int WAKE_SHORT = 4,
   parameter int WAKE_LONG  = 16
)
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_i,
   // Watched ports
   input wire logic global_powerdown_bit_i,
   input wire logic spi_sen_n_i,
   input wire logic spi_sdo_oe_o,
   input wire logic global_powerdown_active_o,
   input wire logic converter_core_on_o,
   input wire logic clock_buffer_on_o,
   input wire logic reference_amp_on_o,
   input wire logic bandgap_on_o,
   input wire logic wake_done_o,
   input wire logic sync_pulse_o,
   input wire logic single_ended_clock_select_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);
   int wait_cnt;
   // Cycles spent powered up but not yet awake
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i || global_powerdown_active_o || wake_done_o)
         wait_cnt <= 0;
      else
         wait_cnt <= wait_cnt + 1;
   end
   pd_follow_a: assert property (
      global_powerdown_bit_i |=> global_powerdown_active_o)
      else $error("power-down request not followed");
   core_off_a: assert property (
      global_powerdown_active_o [*2] |-> !converter_core_on_o)
      else $error("core stays on in power-down");
   core_on_a: assert property (
      !global_powerdown_active_o [*2] |-> converter_core_on_o)
      else $error("core off outside power-down");
   keep_on_a: assert property (
      converter_core_on_o [*2] |-> reference_amp_on_o && bandgap_on_o)
      else $error("block off while core is on");
   clkbuf_up_a: assert property (
      converter_core_on_o [*2] |->
      clock_buffer_on_o == !single_ended_clock_select_o)
      else $error("clock buffer state wrong while up");
   se_clk_a: assert property (
      single_ended_clock_select_o |-> !clock_buffer_on_o)
      else $error("clock buffer on with single-ended clock");
   wake_low_a: assert property (
      global_powerdown_active_o [*2] |-> !wake_done_o)
      else $error("awake flag high in power-down");
   wake_min_a: assert property (
      $rose(wake_done_o) |-> wait_cnt >= WAKE_SHORT - 2)
      else $error("wake-up too early");
   wake_max_a: assert property (
      wait_cnt <= WAKE_LONG + 3)
      else $error("wake-up too late");
   pulse_one_a: assert property (
      sync_pulse_o |=> !sync_pulse_o)
      else $error("sync pulse longer than one cycle");
   sdo_idle_a: assert property (
      spi_sen_n_i [*4] |-> !spi_sdo_oe_o)
      else $error("serial output driven outside a frame");
endmodule

bind converter_power_sync_config_regs cfg_bank_props #(
   .WAKE_SHORT (WAKE_SHORT),
   .WAKE_LONG  (WAKE_LONG)
) i_cfg_bank_props (
   .clk_sys_i (clk_sys_i), .reset_i (reset_i),
   .global_powerdown_bit_i (global_powerdown_bit_i),
   .spi_sen_n_i (spi_sen_n_i), .spi_sdo_oe_o (spi_sdo_oe_o),
   .global_powerdown_active_o (global_powerdown_active_o),
   .converter_core_on_o (converter_core_on_o),
   .clock_buffer_on_o (clock_buffer_on_o),
   .reference_amp_on_o (reference_amp_on_o),
   .bandgap_on_o (bandgap_on_o), .wake_done_o (wake_done_o),
   .sync_pulse_o (sync_pulse_o),
   .single_ended_clock_select_o (single_ended_clock_select_o)
);

// [tb/spi_host_model.sv]
// Host model of the serial port: one command byte, one data byte.
// Assumes mode 0 and a system clock that oversamples SCLK.
`timescale 1ns/1ps
module spi_host_model
(
   // Clock
   input  wire logic clk_sys_i,
   // Serial pins
   output logic      spi_sen_n_o,
   output logic      spi_sclk_o,
   output logic      spi_sdi_o,
   input  wire logic spi_sdo_i,
   input  wire logic spi_sdo_oe_i
);
   logic [7:0] rdata;
   event       done;
   initial
   begin
      spi_sen_n_o = 1'b1;
      spi_sclk_o  = 1'b0;
      spi_sdi_o   = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask
   // Half SCLK period hp in system clocks, 5 or more
   task automatic xfer(input logic rd, input logic [6:0] a,
                       input logic [7:0] d, input int hp);
      logic [15:0] f;
      f = {rd, a, d};
      // Last read stays until the bench has taken it
      wait_clk(1);
      rdata = 8'h00;
      spi_sen_n_o = 1'b0;
      for (int i = 0; i < 16; i++)
      begin
         spi_sdi_o = f[15-i];
         wait_clk(hp);
         if (i > 7)
            rdata = {rdata[6:0], spi_sdo_oe_i ? spi_sdo_i : 1'bx};
         spi_sclk_o = 1'b1;
         wait_clk(hp);
         spi_sclk_o = 1'b0;
      end
      wait_clk(hp);
      spi_sen_n_o = 1'b1;
      // Released data line must not keep its last value
      spi_sdi_o = ~spi_sdi_o;
      wait_clk(4);
      if (rd)
         -> done;
   endtask
endmodule

// [tb/tb.sv]
// Self-checking bench for the converter configuration bank.
// Assumes the serial host model and the bound port checker.
`timescale 1ns/1ps
module tb;
   import converter_cfg_pkg::*;
   localparam int WS = 4;
   localparam int WL = 16;
   logic       clk_sys_i  = 1'b0;
   logic       reset_i    = 1'b1;
   logic       gpd_bit    = 1'b0;
   logic       shared_pin = 1'b0;
   logic [1:0] ref_pin    = 2'h0;
   logic       sen_n, sclk, sdi, sdo, sdo_oe, gpd_act, core_on, wake_done;
   logic       clkbuf_on, refamp_on, bg_on, sync_p, se_clk;
   logic       se_a, se_b, dll_pd, autozero_enable;
   logic [1:0] ref_src;
   logic [7:0] v;
   logic [2:0] mk;
   logic [7:0] exp_q[$];
   int         n_mismatch = 0;
   int         compares   = 0;
   int         n_pulse    = 0;
   int         n;
   always #2.5 clk_sys_i = ~clk_sys_i;
   converter_power_sync_config_regs #(.WAKE_SHORT(WS), .WAKE_LONG(WL))
   i_converter_power_sync_config_regs (
      .clk_sys_i (clk_sys_i), .reset_i (reset_i),
      .global_powerdown_bit_i (gpd_bit), .spi_sen_n_i (sen_n),
      .spi_sclk_i (sclk), .spi_sdi_i (sdi), .spi_sdo_o (sdo),
      .spi_sdo_oe_o (sdo_oe), .sync_powerdown_shared_pin_i (shared_pin),
      .reference_buffer_pin_i (ref_pin),
      .global_powerdown_active_o (gpd_act), .converter_core_on_o (core_on),
      .clock_buffer_on_o (clkbuf_on), .reference_amp_on_o (refamp_on),
      .bandgap_on_o (bg_on), .wake_done_o (wake_done),
      .sync_pulse_o (sync_p), .reference_source_o (ref_src),
      .single_ended_clock_select_o (se_clk),
      .chan_a_single_ended_o (se_a), .chan_b_single_ended_o (se_b),
      .delay_loop_powerdown_o (dll_pd), .autozero_enable_o (autozero_enable));
   spi_host_model i_spi_host_model (
      .clk_sys_i (clk_sys_i), .spi_sen_n_o (sen_n), .spi_sclk_o (sclk),
      .spi_sdi_o (sdi), .spi_sdo_i (sdo), .spi_sdo_oe_i (sdo_oe));
   task automatic check(input string nm, input logic [7:0] e,
                        input logic [7:0] s);
      compares++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic end_of_test;
      if (n_mismatch == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic settle;
      repeat (8) @(negedge clk_sys_i);
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      i_spi_host_model.xfer(1'b0, a, d, 5);
   endtask
   task automatic rdx(input logic [6:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      i_spi_host_model.xfer(1'b1, a, 8'h00, 9);
   endtask
   task automatic sy(input logic [7:0] d, input logic p, input int e);
      n = n_pulse;
      wr(OFS_SYNC_REF, d);
      shared_pin = p;
      settle();
      check("sync pulses", 8'(e), 8'(n_pulse - n));
   endtask
   // Read data is compared when the frame returns it
   always @(i_spi_host_model.done)
      check("read data", exp_q.pop_front(), i_spi_host_model.rdata);
   always @(posedge clk_sys_i)
      if (sync_p === 1'b1)
         n_pulse++;
   initial
   begin
      void'($urandom(15));
      repeat (5) @(negedge clk_sys_i);
      reset_i = 1'b0;
      check("reset outs", 8'h3e, {gpd_act, sync_p, core_on, clkbuf_on,
            refamp_on, bg_on, wake_done, se_clk});
      check("reset cfg", 8'h00,
            {2'h0, ref_src, se_a, se_b, dll_pd, autozero_enable});
      rdx(OFS_KEEP_MASK, KEEP_MASK_RST);
      rdx(OFS_SYNC_REF, SYNC_REF_RST);
      // Sampling rate taken as below 40 MSPS, so delay-loop bit is legal
      for (int i = 0; i < 6; i++)
      begin
         v = 8'($urandom) & INPUT_WMASK;
         wr(OFS_INPUT, v);
         rdx(OFS_INPUT, v);
         check("input outs", v, {2'h0, se_a, se_b, 1'b0, dll_pd, 1'b0,
               autozero_enable});
         v = 8'($urandom) & KEEP_MASK_WMASK;
         wr(OFS_KEEP_MASK, v);
         rdx(OFS_KEEP_MASK, v);
      end
      wr(7'h12, 8'h5a);
      rdx(7'h12, 8'h00);
      for (int c = 0; c < 3; c++)
      begin
         ref_pin = 2'(c + 1);
         wr(OFS_SYNC_REF, 8'(8 + c * 2 + c % 2));
         settle();
         check("ref by reg", {4'h0, 2'(c), 1'(c % 2), 1'(1 - c % 2)},
               {4'h0, ref_src, se_clk, clkbuf_on});
         wr(OFS_SYNC_REF, 8'(1 + c * 2));
         settle();
         check("ref by pin", {4'h0, ref_pin, 2'h1},
               {4'h0, ref_src, se_clk, clkbuf_on});
      end
      wr(OFS_SYNC_REF, 8'h00);
      for (int m = 0; m < 8; m++)
      begin
         mk = 3'(m);
         wr(OFS_KEEP_MASK, {4'h0, mk, 1'b0});
         gpd_bit = 1'b1;
         settle();
         check("pd outs", {5'h04, mk[2], mk[1], ~mk[0]},
               {2'h0, gpd_act, wake_done, core_on, clkbuf_on,
               refamp_on, bg_on});
         gpd_bit = 1'b0;
         n = 0;
         while (wake_done !== 1'b1 && n < 100)
         begin
            @(negedge clk_sys_i);
            n++;
         end
         check("wake time", 8'h01, 8'(n >= (mk[0] ? WL : WS) &&
               n <= (mk[0] ? WL : WS) + 4));
         if (n == 100)
            end_of_test();
      end
      sy(8'h00, 1'b1, 0);
      check("pin pd", 8'h01, {7'h0, gpd_act});
      sy(8'h80, 1'b0, 0);
      sy(8'h80, 1'b1, 1);
      sy(8'ha0, 1'b0, 0);
      sy(8'ha0, 1'b1, 0);
      sy(8'he0, 1'b1, 1);
      sy(8'he0, 1'b1, 0);
      rdx(OFS_SYNC_REF, 8'he0);
      sy(8'h40, 1'b0, 0);
      sy(8'h20, 1'b0, 0);
      sy(8'h60, 1'b0, 1);
      settle();
      end_of_test();
   end
endmodule
